/* verilog/iomux_top.sv */
// APB register file and line multiplexer for the three I/O controllers
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module iomux_top
  import iomux_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Package pins
  input  wire logic [TOTAL_LINES-1:0] pad_in,
  output logic      [TOTAL_LINES-1:0] pad_out,
  output logic      [TOTAL_LINES-1:0] pad_oe,
  output logic      [TOTAL_LINES-1:0] pad_pullup_en,
  // Peripheral functions
  input  wire logic [TOTAL_LINES-1:0] per_a_out,
  input  wire logic [TOTAL_LINES-1:0] per_a_oe,
  input  wire logic [TOTAL_LINES-1:0] per_b_out,
  input  wire logic [TOTAL_LINES-1:0] per_b_oe,
  output logic      [TOTAL_LINES-1:0] line_level,
  output logic      [ANA_N-1:0]       analog_input,
  // Interrupt
  output logic                        irq
);

  logic [31:0] attr      [NCTL][NATTR];
  logic [31:0] next_attr [NCTL][NATTR];
  logic [31:0] isr       [NCTL];
  logic [31:0] next_isr  [NCTL];
  logic [31:0] prev_lvl  [NCTL];
  logic [31:0] lvl32     [NCTL];
  logic [31:0] chg       [NCTL];
  logic [31:0] clr_isr   [NCTL];
  logic [31:0] rd_word;
  logic        next_pready;
  logic        next_irq;

  // Address decode
  wire       xfer   = psel & penable & pready;
  wire [1:0] a_ctl  = paddr[CTL_SEL_LSB+1:CTL_SEL_LSB];
  wire [4:0] a_word = paddr[6:2];
  wire [2:0] a_attr = word_attr(a_word);
  wire [1:0] a_kind = word_kind(a_word);
  wire       a_ok   = (paddr[ADDR_W-1:CTL_SEL_LSB+2] == 3'h0) &&
                      (paddr[1:0] == 2'h0) && (a_ctl != CTL_NONE) &&
                      (a_word <= WORD_ISR);
  wire       a_isattr = a_word < WORD_LEVEL;
  wire       wr_attr  = xfer & pwrite & a_ok & a_isattr;

  // Two cycle access phase keeps read data and pready registered
  assign next_pready = psel & penable & ~pready;

  always_comb begin
    rd_word = 32'h0;
    if (a_ok) begin
      if (a_word == WORD_LEVEL)
        rd_word = lvl32[a_ctl];
      else if (a_word == WORD_ISR)
        rd_word = isr[a_ctl];
      else if (a_kind == KIND_STATUS)
        rd_word = attr[a_ctl][a_attr];
    end
  end

  always_comb begin
    for (int c = 0; c < NCTL; c++) begin
      for (int k = 0; k < NATTR; k++) begin
        next_attr[c][k] = attr[c][k];
        if (wr_attr && a_ctl == 2'(c) && a_attr == 3'(k)) begin
          if (a_kind == KIND_SET)
            next_attr[c][k] = attr[c][k] | (pwdata & ctl_mask(c));
          else if (a_kind == KIND_CLR)
            next_attr[c][k] = attr[c][k] & ~pwdata;
        end
      end
    end
  end

  // Read-clear only drops bits already handed out in prdata, so an
  // event landing between capture and completion stays pending
  always_comb begin
    next_irq = 1'b0;
    for (int c = 0; c < NCTL; c++) begin
      chg[c] = (lvl32[c] ^ prev_lvl[c]) & attr[c][A_MASK];
      clr_isr[c] = 32'h0;
      if (xfer && a_ok && a_ctl == 2'(c) && a_word == WORD_ISR)
        clr_isr[c] = pwrite ? pwdata : prdata;
      next_isr[c] = ((isr[c] & ~clr_isr[c]) | chg[c]) & ctl_mask(c);
      next_irq = next_irq | (|(next_isr[c] & attr[c][A_MASK]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pready & ~a_ok;
      if (next_pready)
        prdata <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCTL; c++) begin
        for (int k = 0; k < NATTR; k++)
          attr[c][k] <= attr_reset(k) & ctl_mask(c);
        isr[c]      <= 32'h0;
        prev_lvl[c] <= 32'h0;
      end
      irq          <= 1'b0;
      analog_input <= '0;
    end else begin
      attr         <= next_attr;
      isr          <= next_isr;
      prev_lvl     <= lvl32;
      irq          <= next_irq;
      analog_input <= pad_in[ANA_LSB +: ANA_N];
    end
  end

  // One driver and one filter per controller
  for (genvar c = 0; c < NCTL; c++) begin : g_ctl
    localparam int W  = ctl_width(c);
    localparam int LB = ctl_base(c);
    logic [W-1:0] lvl;

    iomux_line_if #(.W(W)) lif ();

    assign lif.own    = attr[c][A_GPIO][W-1:0];
    assign lif.oe     = attr[c][A_OE][W-1:0];
    assign lif.odata  = attr[c][A_ODAT][W-1:0];
    assign lif.md     = attr[c][A_MD][W-1:0];
    assign lif.pu     = attr[c][A_PU][W-1:0];
    assign lif.selb   = attr[c][A_SELB][W-1:0];
    assign lif.pa_out = per_a_out[LB +: W];
    assign lif.pa_oe  = per_a_oe[LB +: W];
    assign lif.pb_out = per_b_out[LB +: W];
    assign lif.pb_oe  = per_b_oe[LB +: W];

    assign pad_out[LB +: W]       = lif.pad_out;
    assign pad_oe[LB +: W]        = lif.pad_oe;
    assign pad_pullup_en[LB +: W] = lif.pad_pu;
    assign line_level[LB +: W]    = lvl;

    always_comb begin
      lvl32[c]        = 32'h0;
      lvl32[c][W-1:0] = lvl;
    end

    iomux_line u_line (
      .pclk    (pclk),
      .presetn (presetn),
      .lif     (lif.line)
    );

    iomux_in_filter #(.W(W)) u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (pad_in[LB +: W]),
      .filt_en (attr[c][A_FILT][W-1:0]),
      .level   (lvl)
    );
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_access_answer: assert property (
    psel && penable && !pready |=> pready && $stable(paddr))
    else $error("access phase not answered after one cycle");

  a_reset_static: assert property (
    $rose(presetn) |-> (pad_oe == '0) && (&pad_pullup_en))
    else $error("lines not pulled-up inputs after reset");

  a_set_pullup: assert property (
    xfer && pwrite && paddr == OFF_PU_SET |=>
      (attr[0][A_PU] & $past(pwdata)) == $past(pwdata) ##1
      (pad_pullup_en[31:0] & $past(pwdata, 2)) == $past(pwdata, 2))
    else $error("pull-up set write did not reach the pads");

  a_clr_gpio: assert property (
    xfer && pwrite && paddr == OFF_GPIO_CLR |=>
      (attr[0][A_GPIO] & $past(pwdata)) == 32'h0)
    else $error("clear write left bits set");

  a_ctl2_width: assert property (
    attr[2][A_PU][31:24] == 8'h00 && isr[2][31:24] == 8'h00)
    else $error("third controller has lines above 23");

  // First edge after reset still shows the reset level, so skip it
  a_level_follow: assert property (
    $past(presetn) && !attr[0][A_FILT][0] && $past(!attr[0][A_FILT][0])
      |-> line_level[0] == $past(pad_in[0]))
    else $error("unfiltered level does not follow the pin");

  a_glitch_hold: assert property (
    attr[0][A_FILT][7] && pad_in[7] != $past(pad_in[7]) |=>
      $stable(line_level[7]))
    else $error("filtered line moved on a one-sample pulse");

  a_open_drain: assert property (
    $past(attr[1][A_MD][6]) |-> !pad_out[38] &&
      (pad_oe[38] == ($past(attr[1][A_GPIO][6]) ?
        $past(attr[1][A_OE][6] & ~attr[1][A_ODAT][6]) : pad_oe[38])))
    else $error("multi-drive line driven high");

  a_periph_owns: assert property (
    $past(!attr[0][A_GPIO][9] && !attr[0][A_SELB][9] && !attr[0][A_MD][9])
      |-> pad_out[9] == $past(per_a_out[9]) &&
          pad_oe[9] == $past(per_a_oe[9]))
    else $error("peripheral A does not own its line");

  a_gpio_drive: assert property (
    $past(attr[1][A_GPIO][5] && !attr[1][A_MD][5]) |->
      pad_out[37] == $past(attr[1][A_ODAT][5]))
    else $error("general output value not on the pin");

  a_change_flag: assert property (
    attr[2][A_MASK][2] && line_level[66] != prev_lvl[2][2] |=>
      isr[2][2] ##1 irq)
    else $error("line change did not raise flag and interrupt");

  a_read_clear: assert property (
    xfer && !pwrite && a_ok && a_ctl == 2'h2 && a_word == WORD_ISR &&
      prdata[2] && !chg[2][2] |=> !isr[2][2])
    else $error("status read did not clear reported flag");

  a_analog_tap: assert property (
    $past(presetn) |-> analog_input == $past(pad_in[ANA_LSB +: ANA_N]))
    else $error("analog tap does not follow lines 17 to 20");

  c_attr_write: cover property (wr_attr ##1 xfer && !pwrite);
  c_isr_read: cover property (xfer && !pwrite && a_ctl == 2'h2 &&
    a_word == WORD_ISR && |prdata);
  c_irq_rise: cover property ($rose(irq));
  c_glitch: cover property (attr[0][A_FILT][7] &&
    pad_in[7] != $past(pad_in[7]) ##1 pad_in[7] != $past(pad_in[7]));
  c_bad_addr: cover property (pready && pslverr);

endmodule

/* verilog/iomux_pkg.sv */
// Constants, functions and address map shared by the I/O line multiplexer
package iomux_pkg;

  localparam int NCTL        = 3;
  localparam int CTL01_LINES = 32;
  localparam int CTL2_LINES  = 24;
  localparam int TOTAL_LINES = 2 * CTL01_LINES + CTL2_LINES;
  localparam int ADDR_W      = 12;

  // Attribute groups, each one set, clear and status word
  localparam int NATTR  = 8;
  localparam int A_GPIO = 0;
  localparam int A_OE   = 1;
  localparam int A_FILT = 2;
  localparam int A_ODAT = 3;
  localparam int A_MASK = 4;
  localparam int A_MD   = 5;
  localparam int A_PU   = 6;
  localparam int A_SELB = 7;

  localparam logic [1:0] KIND_SET    = 2'h0;
  localparam logic [1:0] KIND_CLR    = 2'h1;
  localparam logic [1:0] KIND_STATUS = 2'h2;

  localparam int         CTL_SEL_LSB = 7;
  localparam logic [4:0] WORD_LEVEL  = 5'h18;
  localparam logic [4:0] WORD_ISR    = 5'h19;
  localparam logic [1:0] CTL_NONE    = 2'h3;

  localparam logic [ADDR_W-1:0] OFF_GPIO_CLR = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PU_SET   = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_ISR      = 12'h064;

  localparam logic [31:0] MASK_FULL = 32'hffff_ffff;
  localparam logic [31:0] MASK_CTL2 = 32'h00ff_ffff;
  localparam logic [31:0] RST_ONES  = 32'hffff_ffff;
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

  localparam int ANA_LSB = 17;
  localparam int ANA_N   = 4;

  function automatic int ctl_width(input int c);
    return (c == 2) ? CTL2_LINES : CTL01_LINES;
  endfunction

  function automatic int ctl_base(input int c);
    return c * CTL01_LINES;
  endfunction

  function automatic logic [31:0] ctl_mask(input int c);
    return (c == 2) ? MASK_CTL2 : MASK_FULL;
  endfunction

  function automatic logic [31:0] attr_reset(input int k);
    return (k == A_GPIO || k == A_PU) ? RST_ONES : RST_ZERO;
  endfunction

  function automatic logic [2:0] word_attr(input logic [4:0] w);
    return 3'(w / 5'd3);
  endfunction

  function automatic logic [1:0] word_kind(input logic [4:0] w);
    return 2'(w % 5'd3);
  endfunction

endpackage

/* verilog/iomux_line_if.sv */
// Configuration and pad signals between the register file and a line driver
`timescale 1ns/10ps
interface iomux_line_if #(parameter int W = 32);
  logic [W-1:0] own;
  logic [W-1:0] oe;
  logic [W-1:0] odata;
  logic [W-1:0] md;
  logic [W-1:0] pu;
  logic [W-1:0] selb;
  logic [W-1:0] pa_out;
  logic [W-1:0] pa_oe;
  logic [W-1:0] pb_out;
  logic [W-1:0] pb_oe;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  logic [W-1:0] pad_pu;

  modport ctl (output own, oe, odata, md, pu, selb,
               output pa_out, pa_oe, pb_out, pb_oe,
               input  pad_out, pad_oe, pad_pu);
  modport line (input  own, oe, odata, md, pu, selb,
                input  pa_out, pa_oe, pb_out, pb_oe,
                output pad_out, pad_oe, pad_pu);
endinterface

/* verilog/iomux_in_filter.sv */
// Input sampling with per-line optional glitch filter
`timescale 1ns/10ps
module iomux_in_filter
  import iomux_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Lines
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] filt_en,
  output logic      [W-1:0] level
);

  logic [W-1:0] last;
  logic [W-1:0] stable;
  logic [W-1:0] next_level;

  // A level must be seen on two samples before a filtered line moves
  assign stable     = ~(last ^ din);
  assign next_level = (~filt_en & din) |
                      (filt_en & ((stable & din) | (~stable & level)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last  <= '0;
      level <= '0;
    end else begin
      last  <= din;
      level <= next_level;
    end
  end

endmodule

/* verilog/iomux_line.sv */
// Output source selection and pad drive for one controller's lines
`timescale 1ns/10ps
module iomux_line
  import iomux_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Configuration and pads
  iomux_line_if.line lif
);

  logic [$bits(lif.own)-1:0] periph_out;
  logic [$bits(lif.own)-1:0] periph_oe;
  logic [$bits(lif.own)-1:0] src_out;
  logic [$bits(lif.own)-1:0] src_oe;

  // Each line takes its own peripheral B signal where selb is set, else its peripheral A signal
  assign periph_out = (lif.selb & lif.pb_out) | (~lif.selb & lif.pa_out);
  assign periph_oe  = (lif.selb & lif.pb_oe) | (~lif.selb & lif.pa_oe);
  // Peripheral ownership ignores the general output value and enable; multi-drive (md) still applies at the pad
  assign src_out = (lif.own & lif.odata) | (~lif.own & periph_out);
  assign src_oe  = (lif.own & lif.oe) | (~lif.own & periph_oe);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lif.pad_out <= '0;
      lif.pad_oe  <= '0;
      lif.pad_pu  <= '1;
    end else begin
      lif.pad_out <= src_out & ~lif.md;
      lif.pad_oe  <= src_oe & ~(lif.md & src_out);
      lif.pad_pu  <= lif.pu;
    end
  end

endmodule

/* tb/iomux_pin_model.sv */
// Package pin model: board drivers, pull-ups and floating lines
`timescale 1ns/10ps
module iomux_pin_model
  import iomux_pkg::*;
(
  // Clock
  input  wire logic                   pclk,
  // Device side
  input  wire logic [TOTAL_LINES-1:0] pad_out,
  input  wire logic [TOTAL_LINES-1:0] pad_oe,
  input  wire logic [TOTAL_LINES-1:0] pad_pullup_en,
  // Board side
  input  wire logic [TOTAL_LINES-1:0] ext_en,
  input  wire logic [TOTAL_LINES-1:0] ext_val,
  output logic      [TOTAL_LINES-1:0] pad_in
);
  logic [TOTAL_LINES-1:0] float_pat = '0;
  // Floating lines wander so a stale level never passes for a real one
  always_ff @(posedge pclk) begin
    float_pat <= ~float_pat;
  end
  // Device drive wins, then board, then pull-up
  always_comb begin
    for (int i = 0; i < TOTAL_LINES; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = pad_pullup_en[i] | float_pat[i];
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the I/O line multiplexer
`timescale 1ns/10ps
module testbench
  import iomux_pkg::*;
;
  localparam int L = TOTAL_LINES;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [L-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, line_level;
  logic [L-1:0] pa_o, pa_e, pb_o, pb_e, ext_en, ext_val;
  logic [ANA_N-1:0] analog_input;
  logic err;
  int n_mismatch = 0;
  int total_checks = 0;

  iomux_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .per_a_out(pa_o), .per_a_oe(pa_e), .per_b_out(pb_o), .per_b_oe(pb_e),
    .line_level(line_level), .analog_input(analog_input), .irq(irq));
  iomux_pin_model pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));

  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [11:0] ad(int c, int k, logic [1:0] kd);
    return 12'(c * 128 + k * 12 + int'(kd) * 4);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_mismatch++;
    rv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rv);
  endtask

  task automatic t_reset;
    chk("oe any", 0, 32'(|pad_oe));
    chk("pu all", 1, 32'(&pad_pullup_en));
    rdc("gpio0", ad(0, A_GPIO, KIND_STATUS), 32'hffff_ffff);
    rdc("gpio2", ad(2, A_GPIO, KIND_STATUS), 32'h00ff_ffff);
    rdc("pu1", ad(1, A_PU, KIND_STATUS), 32'hffff_ffff);
    rdc("oe1", ad(1, A_OE, KIND_STATUS), 32'h0);
  endtask

  task automatic t_gpio;
    apb(1, ad(1, A_OE, KIND_SET), 32'h60);
    apb(1, ad(1, A_ODAT, KIND_SET), 32'h20);
    repeat (2) @(posedge pclk);
    chk("oe37", 1, 32'(pad_oe[37]));
    chk("out37", 1, 32'(pad_out[37]));
    apb(1, ad(1, A_ODAT, KIND_CLR), 32'h20);
    repeat (2) @(posedge pclk);
    chk("out37 clr", 0, 32'(pad_out[37]));
    rdc("oe1 st", ad(1, A_OE, KIND_STATUS), 32'h60);
  endtask

  task automatic t_drain;
    apb(1, ad(1, A_MD, KIND_SET), 32'h40);
    apb(1, ad(1, A_ODAT, KIND_SET), 32'h40);
    apb(1, ad(1, A_PU, KIND_CLR), 32'h40);
    repeat (2) @(posedge pclk);
    chk("md hi oe", 0, 32'(pad_oe[38]));
    chk("pu38", 0, 32'(pad_pullup_en[38]));
    chk("pu39", 1, 32'(pad_pullup_en[39]));
    apb(1, ad(1, A_ODAT, KIND_CLR), 32'h40);
    repeat (2) @(posedge pclk);
    chk("md lo", 32'h2, {30'h0, pad_oe[38], pad_out[38]});
    apb(1, ad(0, A_PU, KIND_CLR), 32'h1);
    repeat (2) @(posedge pclk);
    chk("pu0 clr", 0, 32'(pad_pullup_en[0]));
    apb(1, OFF_PU_SET, 32'h1);
    repeat (2) @(posedge pclk);
    chk("pu0 set", 1, 32'(pad_pullup_en[0]));
  endtask

  task automatic t_periph;
    apb(1, ad(0, A_OE, KIND_SET), 32'h8);
    apb(1, ad(0, A_GPIO, KIND_CLR), 32'h208);
    pa_o[3] <= 1;
    pa_o[9] <= 1;
    pa_e[3] <= 1;
    pa_e[9] <= 1;
    pb_e[3] <= 1;
    repeat (3) @(posedge pclk);
    chk("fa", 32'h3, {30'h0, pad_out[3], pad_out[9]});
    apb(1, ad(0, A_SELB, KIND_SET), 32'h8);
    repeat (2) @(posedge pclk);
    chk("fb out", 0, 32'(pad_out[3]));
    chk("fb oe", 1, 32'(pad_oe[3]));
    pb_e[3] <= 0;
    repeat (3) @(posedge pclk);
    chk("fb rel", 0, 32'(pad_oe[3]));
  endtask

  task automatic t_level;
    ext_en[63:32] <= '1;
    ext_val[63:32] <= 32'ha5c3_0f1e;
    ext_en[20:17] <= '1;
    ext_val[20:17] <= 4'ha;
    repeat (4) @(posedge pclk);
    rdc("lvl1", 12'(128 + 4 * int'(WORD_LEVEL)), 32'ha5c3_0f1e);
    chk("ana", 32'ha, 32'(analog_input));
    chk("pin9", 1, 32'(line_level[9]));
  endtask

  task automatic t_filter;
    apb(1, ad(0, A_FILT, KIND_SET), 32'h80);
    ext_en[7] <= 1;
    ext_val[7] <= 0;
    @(posedge pclk);
    ext_en[7] <= 0;
    repeat (4) @(posedge pclk);
    chk("glitch", 1, 32'(line_level[7]));
    ext_en[7] <= 1;
    repeat (4) @(posedge pclk);
    chk("held", 0, 32'(line_level[7]));
  endtask

  task automatic t_irq;
    apb(1, ad(2, A_MASK, KIND_SET), 32'h4);
    apb(0, 12'(256 + 4 * int'(WORD_ISR)), 0);
    chk("irq idle", 0, 32'(irq));
    ext_en[66] <= 1;
    ext_val[66] <= 0;
    repeat (5) @(posedge pclk);
    chk("irq set", 1, 32'(irq));
    rdc("isr2", 12'(256 + 4 * int'(WORD_ISR)), 32'h4);
    repeat (3) @(posedge pclk);
    chk("irq clr", 0, 32'(irq));
  endtask

  task automatic t_unmapped;
    apb(0, 12'h180, 0);
    chk("err rd", 1, 32'(err));
    chk("err data", 0, rv);
    apb(1, 12'h002, 32'h1);
    chk("err align", 1, 32'(err));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(25ns * 20000);
    n_mismatch++;
    final_report;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pa_o, pa_e, pb_o, pb_e, ext_en, ext_val} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_gpio;
    t_drain;
    t_periph;
    t_level;
    t_filter;
    t_irq;
    t_unmapped;
    final_report;
  end
endmodule
